// ==== verilog/vdc_pkg.sv ====
// Constants and types shared by the video DMA channel setup block.
// Assumes byte offsets on the register port and one 40 MHz clock.
package vdc_pkg;

  // Register count and byte offsets of the programming set.
  localparam int         NUM_REGS          = 11;
  localparam logic [7:0] OFS_CH1_ODD_BASE  = 8'h00;
  localparam logic [7:0] OFS_CH1_EVEN_BASE = 8'h04;
  localparam logic [7:0] OFS_CH1_GUARD     = 8'h08;
  localparam logic [7:0] OFS_CH1_STRIDE    = 8'h0c;
  localparam logic [7:0] OFS_CH1_PAGE      = 8'h10;
  localparam logic [7:0] OFS_CH1_COUNTS    = 8'h14;
  localparam logic [7:0] OFS_CH2_ODD_BASE  = 8'h18;
  localparam logic [7:0] OFS_CH2_EVEN_BASE = 8'h1c;
  localparam logic [7:0] OFS_CH2_GUARD     = 8'h20;
  localparam logic [7:0] OFS_CH2_STRIDE    = 8'h24;
  localparam logic [7:0] OFS_CH2_PAGE      = 8'h28;

  // Field positions inside the page and count registers.
  localparam int PAGE_BASE_LSB = 12;
  localparam int MAP_EN_BIT    = 11;
  localparam int LIMIT_LSB     = 4;
  localparam int LIMIT_MSB     = 7;
  localparam int VIOL_BIT      = 3;
  localparam int DIR_BIT       = 2;
  localparam int SWAP_LSB      = 0;
  localparam int SWAP_MSB      = 1;
  localparam int LINES_LSB     = 16;
  localparam int LINES_MSB     = 27;
  localparam int PIX_LSB       = 0;
  localparam int PIX_MSB       = 11;

  // Writable bits per register, highest index first; reserved bits read zero.
  localparam logic [NUM_REGS-1:0][31:0] REG_MASK = {
    32'hfffff8fc, 32'hffffffff, 32'hfffffffc, 32'hffffffff, 32'hffffffff,
    32'h0fff0fff, 32'hfffff8fb, 32'hffffffff, 32'hfffffffc, 32'hffffffff,
    32'hffffffff};
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // Address step per doubleword and the base added to the range limit to form the range exponent.
  localparam logic [31:0] ADDR_STEP        = 32'h00000004;
  localparam logic [4:0]  RANGE_SHIFT_BASE = 5'h06;

  // Byte order codes of the channel 1 data path.
  typedef enum logic [1:0] {
    SWAP_NONE = 2'b00,
    SWAP_HALF = 2'b01,
    SWAP_FULL = 2'b10,
    SWAP_RSVD = 2'b11
  } vdc_swap_t;

  // Address generator states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } vdc_state_t;

endpackage

// ==== verilog/vdc_addr_gen.sv ====
// Per-channel transfer address generator: field base, line stride, range and guard checks.
// Assumes field, line and word strobes are single-cycle pulses from the FIFO control.
`timescale 1ns/100ps
module vdc_addr_gen (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        fieldStart,
  input  wire logic        fieldOdd,
  input  wire logic        lineStart,
  input  wire logic        wordStep,
  input  wire logic [31:0] oddBase,
  input  wire logic [31:0] evenBase,
  input  wire logic [31:0] lineStride,
  input  wire logic [31:0] guardLimit,
  input  wire logic [3:0]  rangeLimit,
  input  wire logic        violationStop,
  output logic      [31:0] addr,
  output logic             rangeCross,
  output logic             guardHit,
  output logic             busy,
  output logic             halted
);

  vdc_pkg::vdc_state_t state;
  vdc_pkg::vdc_state_t next_state;
  logic [31:0] lineAddr;
  logic [31:0] next_lineAddr;
  logic [31:0] next_addr;
  logic        next_rangeCross;
  logic        next_guardHit;
  logic        moved;
  logic [4:0]  shift;

  // Field start wins over line start, which wins over a word step.
  always_comb begin
    next_state      = state;
    next_lineAddr   = lineAddr;
    next_addr       = addr;
    moved           = 1'b0;
    shift           = {1'b0, rangeLimit} + vdc_pkg::RANGE_SHIFT_BASE;
    if (fieldStart) begin
      next_lineAddr = fieldOdd ? oddBase : evenBase;
      next_addr     = fieldOdd ? oddBase : evenBase;
      next_state    = vdc_pkg::ST_RUN;
    end else if (state == vdc_pkg::ST_RUN && lineStart) begin
      next_lineAddr = lineAddr + lineStride;
      next_addr     = lineAddr + lineStride;
      moved         = 1'b1;
    end else if (state == vdc_pkg::ST_RUN && wordStep) begin
      next_addr = addr + vdc_pkg::ADDR_STEP;
      moved     = 1'b1;
    end
    // A zero limit field disables range events; the smallest range is 128 bytes.
    next_rangeCross = moved && rangeLimit != 4'h0
                      && ((next_addr ^ addr) >> shift) != 32'h0;
    // Only doubleword bits take part, since the guard's two low bits are reserved.
    next_guardHit = (moved || fieldStart) && next_addr[31:2] >= guardLimit[31:2];
    if (next_guardHit && violationStop) begin
      next_state = vdc_pkg::ST_HALT;
    end
  end

  // State registers of the generator.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state      <= vdc_pkg::ST_IDLE;
      lineAddr   <= 32'h0;
      addr       <= 32'h0;
      rangeCross <= 1'b0;
      guardHit   <= 1'b0;
    end else begin
      state      <= next_state;
      lineAddr   <= next_lineAddr;
      addr       <= next_addr;
      rangeCross <= next_rangeCross;
      guardHit   <= next_guardHit;
    end
  end

  assign busy   = (state == vdc_pkg::ST_RUN);
  assign halted = (state == vdc_pkg::ST_HALT);

endmodule

// ==== verilog/vdc_channel_setup.sv ====
// Programming set of video DMA channels 1 and 2 with their address generators,
// the channel 1 byte reorder path and the scaler input line and pixel cut-off.
// Assumes a simple synchronous register port decoded from the PCI base address.
`timescale 1ns/100ps
// Summary of operation
// - Channel 1 starts each field at its odd or even base, bottom-left for a negative stride.
// - Channel 2 starts each field at its odd or even base, bottom-left under top-down flip.
// - Each next line starts at the previous line start plus the full signed 32-bit stride.
// - The page table base of each channel is bits 31 to 12 of its page register, 4 KB aligned.
// - A set mapping enable bit routes channel addresses via the address mapper, else bypassed.
// - A 4-bit range limit sizes a memory range; crossing its boundary raises an event.
// - Channel 1 reorders each doubleword by its 2-bit byte order field; code 11 is reserved.
// - Only the programmed number of lines per field reaches the scaler; later lines drop.
// - Only the programmed number of pixels per line reaches the scaler; later pixels drop.
// - Channel 1 only writes to PCI memory and never reads.
// - The channel 2 direction bit selects a write to memory when 0 and a read when 1.
module vdc_channel_setup (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  output logic             regRdataValid,
  input  wire logic        ch1FieldStart,
  input  wire logic        ch1FieldOdd,
  input  wire logic        ch1LineStart,
  input  wire logic        ch1WordStep,
  output logic      [31:0] ch1Addr,
  output logic             ch1MapEnable,
  output logic      [19:0] ch1PageTableBase,
  output logic             ch1ReadMode,
  output logic             ch1RangeIrq,
  output logic             ch1GuardHit,
  output logic             ch1Busy,
  output logic             ch1Halted,
  input  wire logic        ch2FieldStart,
  input  wire logic        ch2FieldOdd,
  input  wire logic        ch2LineStart,
  input  wire logic        ch2WordStep,
  output logic      [31:0] ch2Addr,
  output logic             ch2MapEnable,
  output logic      [19:0] ch2PageTableBase,
  output logic             ch2ReadMode,
  output logic             ch2RangeIrq,
  output logic             ch2GuardHit,
  output logic             ch2Busy,
  output logic             ch2Halted,
  input  wire logic [31:0] ch1DataIn,
  input  wire logic        ch1DataInValid,
  output logic      [31:0] ch1DataOut,
  output logic             ch1DataOutValid,
  input  wire logic [15:0] pixIn,
  input  wire logic        pixInValid,
  input  wire logic        pixLineEnd,
  input  wire logic        pixFieldStart,
  output logic      [15:0] pixOut,
  output logic             pixOutValid
);

  logic [vdc_pkg::NUM_REGS-1:0][31:0] regFile;
  logic [vdc_pkg::NUM_REGS-1:0][31:0] next_regFile;
  logic [5:0]  regIndex;
  logic        regHit;
  logic [31:0] next_regRdata;
  logic [31:0] ch1Page;
  logic [31:0] ch2Page;
  logic [31:0] ch1Counts;
  logic [1:0]  swapCode;
  logic [31:0] next_ch1DataOut;
  logic [11:0] lineCnt;
  logic [11:0] pixCnt;
  logic [11:0] next_lineCnt;
  logic [11:0] next_pixCnt;
  logic [11:0] effLine;
  logic [11:0] effPix;
  logic        pixPass;
  logic [15:0] next_pixOut;

  // Word index decode; misaligned or unmapped offsets are ignored and read zero.
  assign regIndex = regAddr[7:2];
  assign regHit   = (regAddr[1:0] == 2'b00) && (regIndex < 6'(vdc_pkg::NUM_REGS));

  // One write path per register; the mask keeps reserved bits at zero.
  genvar gi;
  generate
    for (gi = 0; gi < vdc_pkg::NUM_REGS; gi++) begin : g_reg
      always_comb begin
        next_regFile[gi] = regFile[gi];
        if (regWrite && regHit && regIndex == 6'(gi)) begin
          next_regFile[gi] = regWdata & vdc_pkg::REG_MASK[gi];
        end
      end
    end
  endgenerate

  // Read data is captured so that it stands still until the next read.
  always_comb begin
    next_regRdata = regRdata;
    if (regRead) begin
      next_regRdata = regHit ? regFile[regIndex[3:0]] : 32'h0;
    end
  end

  // Register file and read port state.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regFile       <= {vdc_pkg::NUM_REGS{vdc_pkg::REG_RESET}};
      regRdata      <= 32'h0;
      regRdataValid <= 1'b0;
    end else begin
      regFile       <= next_regFile;
      regRdata      <= next_regRdata;
      regRdataValid <= regRead;
    end
  end

  assign ch1Page   = regFile[vdc_pkg::OFS_CH1_PAGE[7:2]];
  assign ch2Page   = regFile[vdc_pkg::OFS_CH2_PAGE[7:2]];
  assign ch1Counts = regFile[vdc_pkg::OFS_CH1_COUNTS[7:2]];

  // Page table base and mapper select go straight to the address mapper.
  assign ch1PageTableBase = ch1Page[31:vdc_pkg::PAGE_BASE_LSB];
  assign ch2PageTableBase = ch2Page[31:vdc_pkg::PAGE_BASE_LSB];
  assign ch1MapEnable     = ch1Page[vdc_pkg::MAP_EN_BIT];
  assign ch2MapEnable     = ch2Page[vdc_pkg::MAP_EN_BIT];
  // Channel 1 has no read path at all, so its direction is fixed.
  assign ch1ReadMode      = 1'b0;
  assign ch2ReadMode      = ch2Page[vdc_pkg::DIR_BIT];

  // Channel 1 address generator; flip and negative stride need no extra logic.
  vdc_addr_gen u_ch1 (
    .clock         (clock),
    .rst_n         (rst_n),
    .fieldStart    (ch1FieldStart),
    .fieldOdd      (ch1FieldOdd),
    .lineStart     (ch1LineStart),
    .wordStep      (ch1WordStep),
    .oddBase       (regFile[vdc_pkg::OFS_CH1_ODD_BASE[7:2]]),
    .evenBase      (regFile[vdc_pkg::OFS_CH1_EVEN_BASE[7:2]]),
    .lineStride    (regFile[vdc_pkg::OFS_CH1_STRIDE[7:2]]),
    .guardLimit    (regFile[vdc_pkg::OFS_CH1_GUARD[7:2]]),
    .rangeLimit    (ch1Page[vdc_pkg::LIMIT_MSB:vdc_pkg::LIMIT_LSB]),
    .violationStop (ch1Page[vdc_pkg::VIOL_BIT]),
    .addr          (ch1Addr),
    .rangeCross    (ch1RangeIrq),
    .guardHit      (ch1GuardHit),
    .busy          (ch1Busy),
    .halted        (ch1Halted)
  );

  // Channel 2 address generator.
  vdc_addr_gen u_ch2 (
    .clock         (clock),
    .rst_n         (rst_n),
    .fieldStart    (ch2FieldStart),
    .fieldOdd      (ch2FieldOdd),
    .lineStart     (ch2LineStart),
    .wordStep      (ch2WordStep),
    .oddBase       (regFile[vdc_pkg::OFS_CH2_ODD_BASE[7:2]]),
    .evenBase      (regFile[vdc_pkg::OFS_CH2_EVEN_BASE[7:2]]),
    .lineStride    (regFile[vdc_pkg::OFS_CH2_STRIDE[7:2]]),
    .guardLimit    (regFile[vdc_pkg::OFS_CH2_GUARD[7:2]]),
    .rangeLimit    (ch2Page[vdc_pkg::LIMIT_MSB:vdc_pkg::LIMIT_LSB]),
    .violationStop (ch2Page[vdc_pkg::VIOL_BIT]),
    .addr          (ch2Addr),
    .rangeCross    (ch2RangeIrq),
    .guardHit      (ch2GuardHit),
    .busy          (ch2Busy),
    .halted        (ch2Halted)
  );

  // Byte reorder; the reserved code passes data unchanged rather than garbling it.
  assign swapCode = ch1Page[vdc_pkg::SWAP_MSB:vdc_pkg::SWAP_LSB];
  always_comb begin
    case (swapCode)
      vdc_pkg::SWAP_NONE: next_ch1DataOut = ch1DataIn;
      vdc_pkg::SWAP_HALF: next_ch1DataOut = {ch1DataIn[23:16], ch1DataIn[31:24],
                                             ch1DataIn[7:0], ch1DataIn[15:8]};
      vdc_pkg::SWAP_FULL: next_ch1DataOut = {ch1DataIn[7:0], ch1DataIn[15:8],
                                             ch1DataIn[23:16], ch1DataIn[31:24]};
      default:            next_ch1DataOut = ch1DataIn;
    endcase
    if (!ch1DataInValid) begin
      next_ch1DataOut = ch1DataOut;
    end
  end

  // A field start resets the counts for the pixel of the same cycle.
  always_comb begin
    effLine      = pixFieldStart ? 12'h0 : lineCnt;
    effPix       = pixFieldStart ? 12'h0 : pixCnt;
    pixPass      = pixInValid
                   && effLine < ch1Counts[vdc_pkg::LINES_MSB:vdc_pkg::LINES_LSB]
                   && effPix < ch1Counts[vdc_pkg::PIX_MSB:vdc_pkg::PIX_LSB];
    next_pixCnt  = pixPass ? effPix + 12'h1 : effPix;
    next_lineCnt = effLine;
    if (pixLineEnd) begin
      next_pixCnt = 12'h0;
      // Saturating at the limit keeps a long field from wrapping back into range.
      if (effLine < ch1Counts[vdc_pkg::LINES_MSB:vdc_pkg::LINES_LSB]) begin
        next_lineCnt = effLine + 12'h1;
      end
    end
    next_pixOut = pixPass ? pixIn : pixOut;
  end

  // Data path and cut-off counter registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch1DataOut      <= 32'h0;
      ch1DataOutValid <= 1'b0;
      lineCnt         <= 12'h0;
      pixCnt          <= 12'h0;
      pixOut          <= 16'h0;
      pixOutValid     <= 1'b0;
    end else begin
      ch1DataOut      <= next_ch1DataOut;
      ch1DataOutValid <= ch1DataInValid;
      lineCnt         <= next_lineCnt;
      pixCnt          <= next_pixCnt;
      pixOut          <= next_pixOut;
      pixOutValid     <= pixPass;
    end
  end

endmodule

// ==== sim/vdc_channel_setup_checker.sv ====
// Concurrent checks of the video DMA channel setup block, bound to its top module.
// Assumes register writes never share a clock edge with field strobes or data.
`timescale 1ns/100ps
module vdc_channel_setup_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        regWrite,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        ch1FieldStart,
  input wire logic        ch1FieldOdd,
  input wire logic        ch1LineStart,
  input wire logic        ch1WordStep,
  input wire logic [31:0] ch1Addr,
  input wire logic        ch1MapEnable,
  input wire logic [19:0] ch1PageTableBase,
  input wire logic        ch1ReadMode,
  input wire logic        ch1RangeIrq,
  input wire logic        ch1GuardHit,
  input wire logic        ch1Busy,
  input wire logic        ch1Halted,
  input wire logic        ch2FieldStart,
  input wire logic        ch2FieldOdd,
  input wire logic [31:0] ch2Addr,
  input wire logic        ch2ReadMode,
  input wire logic [31:0] ch1DataIn,
  input wire logic        ch1DataInValid,
  input wire logic [31:0] ch1DataOut,
  input wire logic        ch1DataOutValid
);
  logic [31:0] odd1, even1, guard1, stride1, ch1_page_and_control, odd2, even2, ch2_page_and_control, line1;

  // Shadow registers, so expectations never lean on design internals.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {odd1, even1, guard1, stride1, ch1_page_and_control, odd2, even2, ch2_page_and_control, line1} <= '0;
    end else begin
      if (regWrite) begin
        case (regAddr)
          8'h00: odd1 <= regWdata;
          8'h04: even1 <= regWdata;
          8'h08: guard1 <= regWdata;
          8'h0c: stride1 <= regWdata;
          8'h10: ch1_page_and_control <= regWdata;
          8'h18: odd2 <= regWdata;
          8'h1c: even2 <= regWdata;
          8'h28: ch2_page_and_control <= regWdata;
          default: ;
        endcase
      end
      if (ch1FieldStart) line1 <= ch1FieldOdd ? odd1 : even1;
      else if (ch1LineStart && ch1Busy && !ch1Halted) line1 <= line1 + stride1;
    end
  end

  // Reserved code 11 passes the word unchanged, like 00.
  function automatic logic [31:0] swapped(input logic [31:0] d, input logic [1:0] m);
    case (m)
      2'b01: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      2'b10: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: return d;
    endcase
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_field1;
    ch1FieldStart |=> ch1Addr == ($past(ch1FieldOdd) ? $past(odd1) : $past(even1));
  endproperty
  a_field1: assert property (p_field1) else $error("channel 1 field start address wrong");
  property p_field2;
    ch2FieldStart |=> ch2Addr == ($past(ch2FieldOdd) ? $past(odd2) : $past(even2));
  endproperty
  a_field2: assert property (p_field2) else $error("channel 2 field start address wrong");
  property p_line;
    ch1LineStart && ch1Busy && !ch1Halted && !ch1FieldStart |=> ch1Addr == line1;
  endproperty
  a_line: assert property (p_line) else $error("line start is not previous plus stride");
  property p_page;
    ch1PageTableBase == ch1_page_and_control[31:12] && ch1MapEnable == ch1_page_and_control[11];
  endproperty
  a_page: assert property (p_page) else $error("page base or mapping enable wrong");
  property p_swap;
    ch1DataInValid |=> ch1DataOutValid
      && ch1DataOut == swapped($past(ch1DataIn), $past(ch1_page_and_control[1:0]));
  endproperty
  a_swap: assert property (p_swap) else $error("reordered doubleword wrong");
  property p_dir;
    !ch1ReadMode && ch2ReadMode == ch2_page_and_control[2];
  endproperty
  a_dir: assert property (p_dir) else $error("transfer direction wrong");
  property p_range;
    ch1WordStep && ch1Busy && !ch1Halted && !ch1FieldStart && !ch1LineStart |=>
      ch1RangeIrq == (ch1_page_and_control[7:4] != 4'h0 &&
      ((ch1Addr ^ $past(ch1Addr)) >> ({1'b0, ch1_page_and_control[7:4]} + 5'h06)) != 32'h0);
  endproperty
  a_range: assert property (p_range) else $error("range crossing event wrong");
  property p_guard;
    ch1GuardHit |-> ch1Addr[31:2] >= guard1[31:2] && (!ch1_page_and_control[3] || ch1Halted);
  endproperty
  a_guard: assert property (p_guard) else $error("guard hit or halt wrong");
endmodule

bind vdc_channel_setup vdc_channel_setup_checker i_chk (.clock, .rst_n, .regWrite, .regAddr,
  .regWdata, .ch1FieldStart, .ch1FieldOdd, .ch1LineStart, .ch1WordStep, .ch1Addr,
  .ch1MapEnable, .ch1PageTableBase, .ch1ReadMode, .ch1RangeIrq, .ch1GuardHit, .ch1Busy,
  .ch1Halted, .ch2FieldStart, .ch2FieldOdd, .ch2Addr, .ch2ReadMode, .ch1DataIn,
  .ch1DataInValid, .ch1DataOut, .ch1DataOutValid);

// ==== sim/vdc_host_mem.sv ====
// Behavioural host memory on the far side of channel 1.
// Assumes each reordered doubleword lands at the channel's current address.
`timescale 1ns/100ps
module vdc_host_mem (
  input  wire logic        clock,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wvalid,
  output logic      [31:0] lastWord,
  output logic      [31:0] lastAddr
);

  // Channel 1 only writes, so the model offers no read path; it keeps the last landing.
  always @(posedge clock) begin
    if (wvalid) begin
      lastWord <= wdata;
      lastAddr <= addr;
    end
  end
endmodule

// ==== sim/vdc_channel_setup_tb_top.sv ====
// Self-checking bench of the video DMA channel setup block.
// Assumes the checker binds itself and the host memory model sits on channel 1.
`timescale 1ns/100ps
module vdc_channel_setup_tb_top;
  logic        clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic        ch1DataInValid = 1'b0;
  logic [7:0]  regAddr = 8'h00, s = 8'h00;
  logic [2:0]  px = 3'h0;
  logic [15:0] pixIn = 16'h0, pixOut;
  logic [31:0] regWdata = 32'h0, ch1DataIn = 32'h0, regRdata, ch1Addr, ch2Addr, ch1DataOut;
  logic [31:0] lastWord, lastAddr;
  logic [19:0] ch1PageTableBase, ch2PageTableBase;
  logic        ch1Busy, ch2Busy, ch2MapEnable, ch2RangeIrq, ch2GuardHit, ch2Halted;
  logic        regRdataValid, ch1MapEnable, ch2ReadMode, ch1RangeIrq, ch1GuardHit;
  logic        ch1Halted, ch1DataOutValid, pixOutValid;
  int          failCount = 0, checkCount = 0, pixSeen = 0;
  logic [31:0] swapExp [4] = '{32'h33221100, 32'h22330011, 32'h00112233, 32'h33221100};

  vdc_channel_setup i_dut (.clock, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .regRdataValid, .ch1FieldStart(s[7]), .ch1FieldOdd(s[6]),
    .ch1LineStart(s[5]), .ch1WordStep(s[4]), .ch1Addr, .ch1MapEnable, .ch1PageTableBase,
    .ch1ReadMode(), .ch1RangeIrq, .ch1GuardHit, .ch1Busy, .ch1Halted,
    .ch2FieldStart(s[3]), .ch2FieldOdd(s[2]), .ch2LineStart(s[1]), .ch2WordStep(s[0]),
    .ch2Addr, .ch2MapEnable, .ch2PageTableBase, .ch2ReadMode, .ch2RangeIrq,
    .ch2GuardHit, .ch2Busy, .ch2Halted, .ch1DataIn, .ch1DataInValid, .ch1DataOut,
    .ch1DataOutValid, .pixIn, .pixInValid(px[2]), .pixLineEnd(px[1]),
    .pixFieldStart(px[0]), .pixOut, .pixOutValid);
  vdc_host_mem i_host (.clock, .addr(ch1Addr), .wdata(ch1DataOut), .wvalid(ch1DataOutValid),
    .lastWord, .lastAddr);

  // Clock and a count of pixels reaching the scaler input.
  always #12.5 clock = ~clock;
  always @(posedge clock) if (pixOutValid === 1'b1) pixSeen++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    // Step off the edge so that outputs derived from the write have settled.
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(32'(regRdataValid), 32'h1);
    chk(regRdata, exp);
  endtask
  // One strobe cycle, keeping both odd-field levels; sampled once the new address lands.
  task automatic st(input logic [7:0] v);
    @(posedge clock);
    s <= v;
    @(posedge clock);
    s <= v & 8'h44;
    #1;
  endtask
  task automatic dat(input logic [31:0] d);
    @(posedge clock);
    ch1DataIn <= d;
    ch1DataInValid <= 1'b1;
    @(posedge clock);
    ch1DataInValid <= 1'b0;
    #1;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #1000000;
    failCount++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < vdc_pkg::NUM_REGS; i++) begin
      rdc(8'(4 * i), 32'h0);
      wr(8'(4 * i), 32'hffffffff);
      rdc(8'(4 * i), vdc_pkg::REG_MASK[i]);
    end
    wr(8'h2c, 32'h12345678);
    rdc(8'h2c, 32'h0);
    wr(8'h02, 32'h0);
    rdc(8'h00, 32'hffffffff);
    chk(32'(ch1MapEnable), 32'h1);
    chk(32'(ch2ReadMode), 32'h1);
    chk(32'(ch2MapEnable), 32'h1);
    chk(32'(ch2PageTableBase), 32'hfffff);
    wr(8'h10, 32'habcde000);
    wr(8'h28, 32'h0);
    chk(32'(ch1PageTableBase), 32'habcde);
    chk(32'(ch1MapEnable), 32'h0);
    chk(32'(ch2ReadMode), 32'h0);
    chk(32'(ch2MapEnable), 32'h0);
    $display("registers done");
    wr(8'h00, 32'h00100000);
    wr(8'h04, 32'h00200000);
    wr(8'h0c, 32'hfffff800);
    wr(8'h10, 32'h0);
    st(8'hc0);
    chk(ch1Addr, 32'h00100000);
    chk(32'(ch1Busy), 32'h1);
    st(8'h60);
    chk(ch1Addr, 32'h000ff800);
    st(8'h50);
    chk(ch1Addr, 32'h000ff804);
    st(8'h60);
    chk(ch1Addr, 32'h000ff000);
    st(8'h80);
    chk(ch1Addr, 32'h00200000);
    wr(8'h18, 32'h00300000);
    wr(8'h1c, 32'h00400000);
    wr(8'h24, 32'h00000100);
    st(8'h0c);
    chk(ch2Addr, 32'h00300000);
    st(8'h06);
    chk(ch2Addr, 32'h00300100);
    st(8'h08);
    chk(ch2Addr, 32'h00400000);
    $display("address walk done");
    wr(8'h10, 32'h00000010);
    wr(8'h00, 32'h00500078);
    st(8'hc0);
    st(8'h50);
    chk(32'(ch1RangeIrq), 32'h0);
    st(8'h50);
    chk(32'(ch1RangeIrq), 32'h1);
    wr(8'h08, 32'h00500084);
    wr(8'h10, 32'h00000008);
    st(8'hc0);
    chk(32'(ch1GuardHit), 32'h0);
    repeat (3) st(8'h50);
    chk(32'(ch1GuardHit), 32'h1);
    chk(32'(ch1Halted), 32'h1);
    chk(32'(ch1Busy), 32'h0);
    st(8'h50);
    chk(ch1Addr, 32'h00500084);
    st(8'hc0);
    chk(32'(ch1Halted), 32'h0);
    // Channel 2 line step that crosses a 128-byte range and meets its guard at once.
    wr(8'h20, 32'h00400100);
    wr(8'h28, 32'h00000018);
    st(8'h02);
    chk(ch2Addr, 32'h00400100);
    chk(32'(ch2RangeIrq), 32'h1);
    chk(32'(ch2GuardHit), 32'h1);
    chk(32'(ch2Halted), 32'h1);
    chk(32'(ch2Busy), 32'h0);
    $display("range and guard done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h10, 32'(m));
      dat(32'h33221100);
      chk(ch1DataOut, swapExp[m]);
    end
    wr(8'h10, 32'h1);
    dat(32'h33221100);
    @(posedge clock);
    #1;
    chk(lastWord, 32'h22330011);
    chk(lastAddr, 32'h00500078);
    $display("byte order done");
    wr(8'h14, 32'h00010002);
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      pixIn <= 16'(i + 1);
      px <= {1'b1, i == 2 || i == 5, i == 0 || i == 6};
    end
    @(posedge clock);
    px <= 3'h0;
    repeat (2) @(posedge clock);
    #1;
    chk(32'(pixSeen), 32'h3);
    chk(32'(pixOut), 32'h7);
    $display("cut-off done");
    end_of_test();
  end
endmodule
